// File: inc/swr_defines.vh
`ifndef SWR_DEFINES_VH
`define SWR_DEFINES_VH

// Frame layout: command byte first, data byte second, MSB first.
`define SWR_FRAME_BITS 16
`define SWR_CNT_W 4
`define SWR_CMD_HI 13
`define SWR_CMD_LO 12
`define SWR_SEL_HI 9
`define SWR_SEL_LO 8
`define SWR_DATA_HI 7
`define SWR_DATA_LO 0

// Command codes.
`define SWR_CMD_NONE 2'h0
`define SWR_CMD_WRITE 2'h1
`define SWR_CMD_HW_POWER_DOWN_N 2'h2

// Channel select bits.
`define SWR_SEL_CH0 0
`define SWR_SEL_CH1 1

// Wiper codes.
`define SWR_WIPER_W 8
`define SWR_MIDSCALE 8'h80
`define SWR_CODE_B 8'h00

// Timing.
`define SWR_CLK_NS 100
`define SWR_RST_MIN_NS 150
`define SWR_RST_CYC ((`SWR_RST_MIN_NS + `SWR_CLK_NS - 1) / `SWR_CLK_NS)
`define SWR_RST_CNT_W 4

// Synchroniser lane order and idle values.
`define SWR_LANE_CS 0
`define SWR_LANE_SCK 1
`define SWR_LANE_SI 2
`define SWR_LANE_RS 3
`define SWR_LANE_PD 4
`define SWR_LANES 5
`define SWR_SYNC_IDLE 5'h19

`endif

// File: rtl/swr_sync.v
`timescale 1ns/1ns
`default_nettype none

// Two flip-flop synchroniser; the first stage feeds only the second.
module swr_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] IDLE = {WIDTH{1'b0}}
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= IDLE;
      stable_reg <= IDLE;
    end else begin
      meta_reg <= async_in;
      stable_reg <= meta_reg;
    end
  end

  assign sync_out = stable_reg;

endmodule

`default_nettype wire

// File: rtl/swr_wiper_ctrl.v
`timescale 1ns/1ns
`default_nettype none
`include "swr_defines.vh"

// Function
// - A fully loaded command runs when chip select rises.
// - Input is taken on serial clock rise; chain output moves on its fall.
// - With chip select high, serial clock and input toggles shift nothing.
// - The chain output is always driven and is low while chip select is high.
// - Hardware reset held low for 150 ns or more loads every wiper with 80h.
// - Power-down low shuts all channels; host keeps it high while selected.
// - Each of two channels owns an 8-bit wiper register of 256 positions.
// - Code 00h sets the wiper at terminal B; higher codes move it toward A.
// - Power-up leaves every wiper register at 80h.
// - Bits gather in the shift register before a wiper register takes them.
// - A serial command can shut down single channels on its own.
// - Shutdown keeps wiper codes; hardware reset changes codes, and taps of channels not shut down.
// - Three commands exist: no operation, wiper write and channel shutdown.
module swr_wiper_ctrl (
  input wire core_clk,
  input wire sys_rst,
  input wire spi_cs_n,
  input wire spi_sck,
  input wire spi_si,
  output wire spi_so,
  input wire hw_midscale_reset_n,
  input wire hw_power_down_n,
  output wire [`SWR_WIPER_W-1:0] wiper_position_ch0,
  output wire [`SWR_WIPER_W-1:0] wiper_position_ch1,
  output wire [`SWR_WIPER_W-1:0] wiper_ch0,
  output wire [`SWR_WIPER_W-1:0] wiper_ch1,
  output wire term_a_open_ch0,
  output wire term_a_open_ch1
);

  localparam ST_IDLE = 2'h1;
  localparam ST_SHIFT = 2'h2;

  ////////////////////////////////////////////////////////////////////////////

  wire [`SWR_LANES-1:0] pins_s;
  wire cs_n_s;
  wire sck_s;
  wire si_s;
  wire rs_n_s;
  wire pd_n_s;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg sck_d_reg;
  reg cs_n_d_reg;
  reg [`SWR_FRAME_BITS-1:0] shift_reg;
  reg [`SWR_CNT_W-1:0] bit_cnt_reg;
  reg frame_seen_reg;
  reg so_reg;
  reg [`SWR_WIPER_W-1:0] pos0_reg;
  reg [`SWR_WIPER_W-1:0] pos1_reg;
  reg [`SWR_WIPER_W-1:0] tap0_reg;
  reg [`SWR_WIPER_W-1:0] tap1_reg;
  reg [1:0] sw_hw_power_down_n_reg;
  reg [1:0] open_a_reg;
  reg [`SWR_RST_CNT_W-1:0] rs_cnt_reg;

  wire sck_rise;
  wire sck_fall;
  wire cs_release;
  wire cs_select;
  wire frame_done;
  wire hw_reset_hit;
  wire [1:0] shut;
  wire [1:0] cmd;
  wire [1:0] sel;

  // Decodes whether a channel is named by the select field.
  function chan_hit;
    input [1:0] sel_field;
    input integer ch;
    begin
      chan_hit = sel_field[ch];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  // The serial clock is slow against core_clk, so both edges are found by
  // sampling; all pins pass the same two stages and stay aligned.
  swr_sync #(
    .WIDTH(`SWR_LANES),
    .IDLE(`SWR_SYNC_IDLE)
  ) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in({hw_power_down_n, hw_midscale_reset_n, spi_si, spi_sck,
               spi_cs_n}),
    .sync_out(pins_s)
  );

  assign cs_n_s = pins_s[`SWR_LANE_CS];
  assign sck_s = pins_s[`SWR_LANE_SCK];
  assign si_s = pins_s[`SWR_LANE_SI];
  assign rs_n_s = pins_s[`SWR_LANE_RS];
  assign pd_n_s = pins_s[`SWR_LANE_PD];

  assign sck_rise = sck_s & ~sck_d_reg & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d_reg & ~cs_n_s;
  assign cs_select = ~cs_n_s & cs_n_d_reg;
  assign cs_release = cs_n_s & ~cs_n_d_reg;
  assign frame_done = frame_seen_reg & (bit_cnt_reg == {`SWR_CNT_W{1'b0}});
  assign cmd = shift_reg[`SWR_CMD_HI:`SWR_CMD_LO];
  assign sel = shift_reg[`SWR_SEL_HI:`SWR_SEL_LO];
  assign hw_reset_hit = (rs_cnt_reg == `SWR_RST_CYC - 1) & ~rs_n_s;
  assign shut = sw_hw_power_down_n_reg | {2{~pd_n_s}};

  ////////////////////////////////////////////////////////////////////////////

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cs_select) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (cs_n_s) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      sck_d_reg <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      sck_d_reg <= sck_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Bits gather here first; nothing reaches a wiper until chip select rises.
  // Only a whole number of frames executes, and only its last frame, so a stray clock is harmless.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg <= {`SWR_FRAME_BITS{1'b0}};
      bit_cnt_reg <= {`SWR_CNT_W{1'b0}};
      frame_seen_reg <= 1'b0;
    end else if (cs_select) begin
      bit_cnt_reg <= {`SWR_CNT_W{1'b0}};
      frame_seen_reg <= 1'b0;
    end else if (sck_rise && state_reg == ST_SHIFT) begin
      shift_reg <= {shift_reg[`SWR_FRAME_BITS-2:0], si_s};
      bit_cnt_reg <= bit_cnt_reg + 1'b1;
      if (bit_cnt_reg == `SWR_FRAME_BITS - 1) begin
        frame_seen_reg <= 1'b1;
      end
    end
  end

  // Chain output follows the bit leaving the register on the falling edge.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      so_reg <= 1'b0;
    end else if (cs_n_s) begin
      so_reg <= 1'b0;
    end else if (sck_fall) begin
      so_reg <= shift_reg[`SWR_FRAME_BITS-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Low time of the reset pin, counted in core_clk cycles.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rs_cnt_reg <= {`SWR_RST_CNT_W{1'b0}};
    end else if (rs_n_s) begin
      rs_cnt_reg <= {`SWR_RST_CNT_W{1'b0}};
    end else if (rs_cnt_reg != `SWR_RST_CYC - 1) begin
      rs_cnt_reg <= rs_cnt_reg + 1'b1;
    end
  end

  // Hardware reset outranks a serial write; the host may not overlap them.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos0_reg <= `SWR_MIDSCALE;
      pos1_reg <= `SWR_MIDSCALE;
      sw_hw_power_down_n_reg <= 2'h0;
    end else if (hw_reset_hit) begin
      pos0_reg <= `SWR_MIDSCALE;
      pos1_reg <= `SWR_MIDSCALE;
    end else if (cs_release && state_reg == ST_SHIFT && frame_done) begin
      case (cmd)
        `SWR_CMD_WRITE: begin
          if (chan_hit(sel, `SWR_SEL_CH0)) begin
            pos0_reg <= shift_reg[`SWR_DATA_HI:`SWR_DATA_LO];
            sw_hw_power_down_n_reg[0] <= 1'b0;
          end
          if (chan_hit(sel, `SWR_SEL_CH1)) begin
            pos1_reg <= shift_reg[`SWR_DATA_HI:`SWR_DATA_LO];
            sw_hw_power_down_n_reg[1] <= 1'b0;
          end
        end
        `SWR_CMD_HW_POWER_DOWN_N: begin
          if (chan_hit(sel, `SWR_SEL_CH0)) begin
            sw_hw_power_down_n_reg[0] <= 1'b1;
          end
          if (chan_hit(sel, `SWR_SEL_CH1)) begin
            sw_hw_power_down_n_reg[1] <= 1'b1;
          end
        end
        default: begin
          sw_hw_power_down_n_reg <= sw_hw_power_down_n_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Applied tap: the code itself, or terminal B while a channel is shut
  // down; the stored code is kept so the wiper returns to it.
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tap0_reg <= `SWR_MIDSCALE;
      tap1_reg <= `SWR_MIDSCALE;
      open_a_reg <= 2'h0;
    end else begin
      open_a_reg <= shut;
      tap0_reg <= shut[0] ? `SWR_CODE_B : pos0_reg;
      tap1_reg <= shut[1] ? `SWR_CODE_B : pos1_reg;
    end
  end

  assign spi_so = so_reg;
  assign wiper_position_ch0 = pos0_reg;
  assign wiper_position_ch1 = pos1_reg;
  assign wiper_ch0 = tap0_reg;
  assign wiper_ch1 = tap1_reg;
  assign term_a_open_ch0 = open_a_reg[0];
  assign term_a_open_ch1 = open_a_reg[1];

endmodule

`default_nettype wire

// File: testbench/swr_wiper_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
module swr_wiper_ctrl_props (
  input wire core_clk,
  input wire sys_rst,
  input wire spi_cs_n,
  input wire spi_sck,
  input wire spi_so,
  input wire hw_midscale_reset_n,
  input wire hw_power_down_n,
  input wire [7:0] wiper_position_ch0,
  input wire [7:0] wiper_position_ch1,
  input wire [7:0] wiper_ch0,
  input wire term_a_open_ch0,
  input wire term_a_open_ch1
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  so_idle_low_a: assert property (spi_cs_n [*4] |-> !spi_so)
    else $error("chain output not low while deselected");
  so_fall_move_a: assert property ($rose(spi_so) |-> !$past(spi_sck))
    else $error("chain output rose outside a low serial clock");
  pd_open_all_a: assert property (!hw_power_down_n [*4] |->
    term_a_open_ch0 && term_a_open_ch1 && wiper_ch0 == 8'h00)
    else $error("power-down did not open both channels");
  rst_midscale_a: assert property (!hw_midscale_reset_n [*2] |-> ##3
    wiper_position_ch0 == 8'h80 && wiper_position_ch1 == 8'h80)
    else $error("hardware reset did not load mid-scale");
  cs_quiet_a: assert property ((spi_cs_n && hw_midscale_reset_n) [*6] |=>
    $stable(wiper_position_ch0) && $stable(wiper_position_ch1))
    else $error("wiper code moved while deselected");
  pos_after_cs_a: assert property (hw_midscale_reset_n &&
    wiper_position_ch0 != $past(wiper_position_ch0) |-> $past(spi_cs_n, 3))
    else $error("wiper code changed before chip select rose");
  sd_tap_b_a: assert property (term_a_open_ch0 |-> wiper_ch0 == 8'h00)
    else $error("shut down channel tap not at terminal B");
  tap_follow_a: assert property ((hw_power_down_n && !term_a_open_ch0 &&
    $stable(wiper_position_ch0)) [*2] |-> wiper_ch0 == wiper_position_ch0)
    else $error("tap does not follow stored code");
  cover property ($rose(spi_cs_n));
  cover property ($fell(hw_midscale_reset_n));
  cover property ($rose(term_a_open_ch0));
endmodule
bind swr_wiper_ctrl swr_wiper_ctrl_props u_props (.core_clk, .sys_rst,
  .spi_cs_n, .spi_sck, .spi_so, .hw_midscale_reset_n, .hw_power_down_n,
  .wiper_position_ch0, .wiper_position_ch1, .wiper_ch0, .term_a_open_ch0,
  .term_a_open_ch1);
`default_nettype wire

// File: testbench/swr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module swr_host_model (
  input wire core_clk,
  input wire spi_so,
  output logic spi_cs_n,
  output logic spi_sck,
  output logic spi_si,
  output logic [15:0] so_seen
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_si = 1'b0;
    so_seen = 16'h0000;
  end
  // Data moves on the falling edge, so it is settled at every rise.
  task automatic send(input logic [31:0] f, input int n);
    int i;
    @(posedge core_clk);
    spi_cs_n <= 1'b0;
    spi_si <= f[n-1];
    for (i = n - 1; i >= 0; i--) begin
      repeat (4) @(posedge core_clk);
      spi_sck <= 1'b1;
      so_seen <= {so_seen[14:0], spi_so};
      repeat (4) @(posedge core_clk);
      spi_sck <= 1'b0;
      spi_si <= (i > 0) ? f[i-1] : ~f[0];
    end
    repeat (4) @(posedge core_clk);
    spi_cs_n <= 1'b1;
  endtask
  task automatic noise();
    repeat (8) @(posedge core_clk) begin
      spi_sck <= ~spi_sck;
      spi_si <= ~spi_si;
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/swr_wiper_ctrl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module swr_wiper_ctrl_tb_top;
  logic core_clk, sys_rst, hw_midscale_reset_n, hw_power_down_n;
  wire spi_cs_n, spi_sck, spi_si, spi_so, term_a_open_ch0, term_a_open_ch1;
  wire [7:0] wiper_position_ch0, wiper_position_ch1, wiper_ch0, wiper_ch1;
  wire [15:0] so_seen;
  int n_checks = 0;
  int miscompares = 0;
  int cycles = 0;
  swr_wiper_ctrl uut (.core_clk, .sys_rst, .spi_cs_n, .spi_sck, .spi_si,
    .spi_so, .hw_midscale_reset_n, .hw_power_down_n, .wiper_position_ch0,
    .wiper_position_ch1, .wiper_ch0, .wiper_ch1, .term_a_open_ch0,
    .term_a_open_ch1);
  swr_host_model host (.core_clk, .spi_so, .spi_cs_n, .spi_sck, .spi_si,
    .so_seen);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // A hung handshake would otherwise stall the run forever.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] f, input int n);
    host.send(f, n);
    repeat (8) @(posedge core_clk);
  endtask
  task automatic pos(input logic [7:0] e0, e1);
    chk("position ch0", {8'h00, wiper_position_ch0}, {8'h00, e0});
    chk("position ch1", {8'h00, wiper_position_ch1}, {8'h00, e1});
  endtask
  task automatic tap(input logic [7:0] e0, e1, input logic o0, o1);
    chk("tap ch0", {8'h00, wiper_ch0}, {8'h00, e0});
    chk("tap ch1", {8'h00, wiper_ch1}, {8'h00, e1});
    chk("open ch0", {15'h0000, term_a_open_ch0}, {15'h0000, o0});
    chk("open ch1", {15'h0000, term_a_open_ch1}, {15'h0000, o1});
  endtask
  initial begin
    sys_rst = 1'b1;
    hw_midscale_reset_n = 1'b1;
    hw_power_down_n = 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    pos(8'h80, 8'h80);
    tap(8'h80, 8'h80, 1'b0, 1'b0);
    chk("chain out", {15'h0000, spi_so}, 16'h0000);
    $display("test power_up done");
    wr(16'h13a5, 16);
    pos(8'ha5, 8'ha5);
    wr(16'h1200, 16);
    pos(8'ha5, 8'h00);
    tap(8'ha5, 8'h00, 1'b0, 1'b0);
    host.noise();
    wr(16'h0077, 16);
    chk("chain after noise", so_seen, 16'h1200);
    wr(16'h3077, 16);
    pos(8'ha5, 8'h00);
    $display("test write done");
    wr(16'h2100, 16);
    pos(8'ha5, 8'h00);
    tap(8'h00, 8'h00, 1'b1, 1'b0);
    wr(32'h113c, 8);
    pos(8'ha5, 8'h00);
    wr(32'h13ff_1166, 32);
    pos(8'h66, 8'h00);
    tap(8'h66, 8'h00, 1'b0, 1'b0);
    chk("chain bits", so_seen, 16'h13ff);
    $display("test shutdown_chain done");
    // Both pins move only while deselected, and reset may fall in power-down.
    hw_power_down_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    tap(8'h00, 8'h00, 1'b1, 1'b1);
    pos(8'h66, 8'h00);
    hw_midscale_reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    hw_midscale_reset_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    pos(8'h80, 8'h80);
    hw_power_down_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    tap(8'h80, 8'h80, 1'b0, 1'b0);
    $display("test pins done");
    complete_run();
  end
endmodule
`default_nettype wire
